//--- hw/adc_seq_ctrl.sv
// Purpose: register file, trigger masking, sequencing and result queue of the converter
// Assumes: converter core answers each request with one done pulse carrying the result
// Notes: conversion clock rate from select code feeds the acquisition timer only
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "adc_seq_cfg.svh"

// Summary of operation
// RL1 - four groups A..D, two or three inputs each, one picked per group
// RL2 - group A picks input 0, 4 or 8; fourth code reserved
// RL3 - group B: 00 input 1, 01 input 5, upper bit set reserved
// RL4 - group C: 00 input 2, 01 input 6, upper bit set reserved
// RL5 - group D in top select bits: 00 input 3, 01 input 7
// RL6 - operation during sleep only with internal RC conversion clock
// RL7 - reset restores registers, turns converter off, abandons conversion
// RL8 - low pin select bits: 1 analog, 0 digital, reset to 1
// RL9 - analog-selected pin has its digital input buffer disabled
// RL10 - high pin select bit 0 controls pin 8, resets 1, rest zero
// RL11 - pin select bits of absent pins read as zero
// RL12 - result reads return queue entry at read pointer, shown in queue control
// RL13 - four-entry circular queue; empty flag bit 3 while nothing unread
// RL14 - overrun flag set when unread entry is overwritten
// RL15 - interrupt depth ignored in single-shot operation
// RL16 - loop depth 00 every write, 01 second and fourth, 10 fourth only
// RL17 - all-zero trigger mask: only software go starts a sequence
// RL18 - mask bits 0..2: external irq zero, timer five, input capture one
// RL19 - mask bit 3 compare match, bit 4 power pwm rising edge
// RL20 - any enabled trigger source starts a sequence
// RL21 - clock code 011 selects internal RC oscillator divided by four
// RL22 - multi-group modes: AB, ABCD, AB paired, AB then CD paired
// RL23 - single-shot end clears go and sets conversion interrupt flag
// RL24 - read pointer resets to 00 at each sequence start
// RL25 - reading low-order result register advances the read pointer; when left-justified the code advances it on the high result register read
// RL26 - setting go while on starts sequence; go reads 1 until done
// RL27 - loop bit: single-shot/continuous; multi bit: one group/sequence
// RL28 - acquisition time inserts whole conversion clock periods before conversion
// RL29 - queue fills successive entries only when enabled, else holds latest
module adc_seq_ctrl
  import adc_seq_pkg::*;
#(
  parameter int PIN_COUNT = 9
)
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic [4:0] TRIG_I,
  input wire logic SLEEP_I,
  output logic [1:0] CONV_GROUP_O,
  output logic [3:0] CONV_CHANNEL_O,
  output logic CONV_START_O,
  output logic PAIR_SAMPLE_O,
  input wire logic [9:0] CONV_DATA_I,
  input wire logic CONV_DONE_I,
  output logic CONVERTER_ON_O,
  output logic RC_CLOCK_SEL_O,
  output logic [8:0] DIGITAL_BUF_EN_O,
  output logic CONV_IRQ_O
);

  typedef struct packed {
    logic [7:0] conv_ctrl;
    logic [7:0] queue_ctrl;
    logic [7:0] timing_fmt;
    logic [7:0] irq_trig;
    logic [7:0] group_sel;
    logic [7:0] pin_lo;
    logic pin_hi;
    logic [3:0][9:0] queue;
    logic [3:0] unread;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic overrun;
    logic irq_flag;
    logic [2:0] wr_count;
    seq_state_e state;
    logic [1:0] step;
    logic [7:0] acq_cnt;
    logic [7:0] tad_cnt;
    logic [4:0] trig_prev;
    logic [7:0] rdata;
    conv_request_s req;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic [4:0] trig_meta_r;
  logic [4:0] trig_sync_r;
  logic [9:0] cdata_r;
  logic cdone_r;

  // acquisition periods in conversion clocks
  function automatic logic [7:0] acq_periods(input logic [3:0] code);
    logic [7:0] n;
    n = 8'h00;
    if (code <= 4'h6)
      n = {3'h0, code, 1'b0};
    else if (code <= 4'hd)
      n = 8'(({4'h0, code} - 8'h3) << 2);
    else if (code == 4'he)
      n = 8'h30;
    else
      n = 8'h40;
    return n;
  endfunction

  // system clocks per conversion clock period
  function automatic logic [7:0] tad_cycles(input logic [2:0] code);
    logic [7:0] n;
    n = 8'h00;
    case (code)
      3'h0: n = 8'h02;
      3'h1: n = 8'h08;
      3'h2: n = 8'h20;
      `RC_DIV4_CODE: n = 8'(`RC_DIV_CYCLES * 4); // [RL21]
      3'h4: n = 8'h04;
      3'h5: n = 8'h10;
      3'h6: n = 8'h40;
      default: n = 8'(`RC_DIV_CYCLES);
    endcase
    return n;
  endfunction

  // channel for a group from its pick field
  function automatic logic [3:0] pick_channel(input logic [1:0] grp, input logic [7:0] sel);
    logic [3:0] ch;
    ch = 4'h0;
    case (grp)
      2'h0: ch = (sel[1:0] == 2'h2) ? 4'h8 : (sel[0] ? 4'h4 : 4'h0); // [RL1] [RL2]
      2'h1: ch = sel[4] ? 4'h5 : 4'h1; // [RL3]
      2'h2: ch = sel[2] ? 4'h6 : 4'h2; // [RL4]
      default: ch = sel[6] ? 4'h7 : 4'h3; // [RL5]
    endcase
    return ch;
  endfunction

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      trig_meta_r <= 5'h00;
      trig_sync_r <= 5'h00;
      cdata_r <= 10'h000;
      cdone_r <= 1'b0;
    end
    else
    begin
      trig_meta_r <= TRIG_I;
      trig_sync_r <= trig_meta_r;
      cdata_r <= CONV_DATA_I;
      cdone_r <= CONV_DONE_I;
    end
  end

  always_comb
  begin
    logic on;
    logic loop_mode;
    logic multi;
    logic [1:0] mode;
    logic trig_hit;
    logic go_start;
    logic last_step;
    logic [1:0] grp;
    logic low_read;
    logic raise;
    on = s_r.conv_ctrl[`BIT_CONVERTER_ON];
    loop_mode = s_r.conv_ctrl[`BIT_LOOP_CONV]; // [RL27]
    multi = s_r.conv_ctrl[`BIT_MULTI_GROUP]; // [RL27]
    mode = s_r.conv_ctrl[3:2];
    s_nxt = s_r;
    s_nxt.req.start = 1'b0;
    s_nxt.trig_prev = trig_sync_r;
    // any enabled source edge; an all-zero mask blocks hardware starts
    trig_hit = |(s_r.irq_trig[4:0] & trig_sync_r & ~s_r.trig_prev); // [RL17] [RL18] [RL19] [RL20]
    go_start = 1'b0;
    raise = 1'b0;
    if (WR_I)
    begin
      if (ADDR_I == `OFS_CONV_CTRL)
      begin
        s_nxt.conv_ctrl = {2'h0, WDATA_I[5:2], s_r.conv_ctrl[`BIT_GO], WDATA_I[0]};
        go_start = WDATA_I[`BIT_GO] & WDATA_I[0] & ~s_r.conv_ctrl[`BIT_GO]; // [RL26]
      end
      else if (ADDR_I == `OFS_QUEUE_CTRL)
        s_nxt.queue_ctrl = {WDATA_I[7:6], 1'b0, WDATA_I[4], 4'h0};
      else if (ADDR_I == `OFS_TIMING_FMT)
        s_nxt.timing_fmt = WDATA_I;
      else if (ADDR_I == `OFS_IRQ_TRIG)
        s_nxt.irq_trig = {WDATA_I[7:6], 1'b0, WDATA_I[4:0]};
      else if (ADDR_I == `OFS_GROUP_SEL)
        s_nxt.group_sel = WDATA_I;
      else if (ADDR_I == `OFS_PIN_SEL_LO)
        s_nxt.pin_lo = WDATA_I; // [RL8]
      else if (ADDR_I == `OFS_PIN_SEL_HI)
        s_nxt.pin_hi = WDATA_I[0]; // [RL10]
      else if (ADDR_I == `OFS_IRQ_FLAG)
        s_nxt.irq_flag = WDATA_I[0];
    end
    if ((on || go_start) && s_r.state == ST_IDLE && (go_start || trig_hit))
    begin
      s_nxt.conv_ctrl[`BIT_GO] = 1'b1; // [RL26]
      s_nxt.rd_ptr = 2'h0; // [RL24]
      s_nxt.step = 2'h0;
      s_nxt.wr_count = 3'h0;
      s_nxt.acq_cnt = acq_periods(s_r.timing_fmt[6:3]);
      s_nxt.tad_cnt = tad_cycles(s_r.timing_fmt[2:0]);
      s_nxt.state = ST_ACQ;
    end
    // step to group: single mode takes group from mode bits
    if (!multi)
    begin
      grp = mode;
      last_step = 1'b1;
    end
    else
    begin
      grp = s_r.step; // [RL22]
      last_step = (mode[0] ? s_r.step == 2'h3 : s_r.step == 2'h1);
    end
    case (s_r.state)
      ST_ACQ:
      begin
        // paired modes sample only before A and C
        if (s_r.acq_cnt == 8'h00 || (multi && mode[1] && s_r.step[0])) // [RL28]
        begin
          s_nxt.req.group = grp;
          s_nxt.req.channel = pick_channel(grp, s_r.group_sel);
          s_nxt.req.start = 1'b1;
          s_nxt.state = ST_CONV;
        end
        else if (s_r.tad_cnt <= 8'h01)
        begin
          s_nxt.tad_cnt = tad_cycles(s_r.timing_fmt[2:0]);
          s_nxt.acq_cnt = s_r.acq_cnt - 8'h01;
        end
        else
          s_nxt.tad_cnt = s_r.tad_cnt - 8'h01;
      end
      ST_CONV:
      begin
        if (cdone_r)
        begin
          s_nxt.queue[s_r.wr_ptr] = cdata_r;
          s_nxt.unread[s_r.wr_ptr] = 1'b1;
          if (s_r.unread[s_r.wr_ptr])
            s_nxt.overrun = 1'b1; // [RL14]
          if (s_r.queue_ctrl[`BIT_QUEUE_ENABLE])
            s_nxt.wr_ptr = s_r.wr_ptr + 2'h1; // [RL13] [RL29]
          s_nxt.wr_count = s_r.wr_count + 3'h1;
          if (loop_mode)
          begin
            case (s_r.irq_trig[7:6]) // [RL15] [RL16]
              2'h0: raise = 1'b1;
              2'h1: raise = s_r.wr_count[0];
              2'h2: raise = (s_r.wr_count[1:0] == 2'h3);
              default: raise = 1'b0;
            endcase
          end
          s_nxt.state = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        s_nxt.state = ST_ACQ;
        s_nxt.acq_cnt = acq_periods(s_r.timing_fmt[6:3]);
        s_nxt.tad_cnt = tad_cycles(s_r.timing_fmt[2:0]);
        if (!last_step)
          s_nxt.step = s_r.step + 2'h1;
        else
        begin
          s_nxt.step = 2'h0;
          if (!loop_mode)
          begin
            s_nxt.conv_ctrl[`BIT_GO] = 1'b0; // [RL23]
            raise = 1'b1; // [RL23]
            s_nxt.state = ST_IDLE;
          end
        end
      end
      default:
      begin
      end
    endcase
    s_nxt.rdata = 8'h00;
    low_read = 1'b0;
    if (RD_I)
    begin
      if (ADDR_I == `OFS_CONV_CTRL)
        s_nxt.rdata = s_r.conv_ctrl;
      else if (ADDR_I == `OFS_QUEUE_CTRL)
        s_nxt.rdata = {s_r.queue_ctrl[7:6], 1'b0, s_r.queue_ctrl[4], ~|s_r.unread,
                       s_r.overrun, s_r.rd_ptr}; // [RL12] [RL13]
      else if (ADDR_I == `OFS_TIMING_FMT)
        s_nxt.rdata = s_r.timing_fmt;
      else if (ADDR_I == `OFS_IRQ_TRIG)
        s_nxt.rdata = s_r.irq_trig;
      else if (ADDR_I == `OFS_GROUP_SEL)
        s_nxt.rdata = s_r.group_sel;
      else if (ADDR_I == `OFS_PIN_SEL_LO)
        s_nxt.rdata = (PIN_COUNT > 5) ? s_r.pin_lo : {3'h0, s_r.pin_lo[4:0]}; // [RL11]
      else if (ADDR_I == `OFS_PIN_SEL_HI)
        s_nxt.rdata = {7'h00, s_r.pin_hi & (PIN_COUNT > 8)}; // [RL10] [RL11]
      else if (ADDR_I == `OFS_RESULT_HI)
      begin
        // [RL12]
        s_nxt.rdata = s_r.timing_fmt[`BIT_JUSTIFY] ? {6'h00, s_r.queue[s_r.rd_ptr][9:8]}
                                                    : s_r.queue[s_r.rd_ptr][9:2];
        low_read = ~s_r.timing_fmt[`BIT_JUSTIFY]; // [RL25]
      end
      else if (ADDR_I == `OFS_RESULT_LO)
      begin
        s_nxt.rdata = s_r.timing_fmt[`BIT_JUSTIFY] ? s_r.queue[s_r.rd_ptr][7:0]
                                                    : {s_r.queue[s_r.rd_ptr][1:0], 6'h00};
        low_read = s_r.timing_fmt[`BIT_JUSTIFY]; // [RL25]
      end
      else if (ADDR_I == `OFS_IRQ_FLAG)
        s_nxt.rdata = {7'h00, s_r.irq_flag};
    end
    if (low_read)
    begin
      // an entry written in the same cycle stays unread
      if (!(cdone_r && s_r.state == ST_CONV && s_r.wr_ptr == s_r.rd_ptr))
        s_nxt.unread[s_r.rd_ptr] = 1'b0;
      if (s_r.queue_ctrl[`BIT_QUEUE_ENABLE])
        s_nxt.rd_ptr = s_r.rd_ptr + 2'h1; // [RL25]
    end
    if (raise)
      s_nxt.irq_flag = 1'b1;
    // turning off, or sleeping with any clock code but plain RC (111, not 011), abandons a sequence
    if (!s_nxt.conv_ctrl[`BIT_CONVERTER_ON] ||
        (SLEEP_I && s_r.timing_fmt[2:0] != `RC_CODE)) // [RL6]
    begin
      s_nxt.state = ST_IDLE;
      s_nxt.conv_ctrl[`BIT_GO] = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      s_r <= '0; // [RL7]
      s_r.pin_lo <= `RST_PIN_SEL_LO; // [RL8]
      s_r.pin_hi <= `RST_PIN_SEL_HI; // [RL10]
      s_r.state <= ST_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign RDATA_O = s_r.rdata;
  assign CONV_GROUP_O = s_r.req.group;
  assign CONV_CHANNEL_O = s_r.req.channel;
  assign CONV_START_O = s_r.req.start;
  assign PAIR_SAMPLE_O = s_r.conv_ctrl[`BIT_MULTI_GROUP] & s_r.conv_ctrl[3];
  assign CONVERTER_ON_O = s_r.conv_ctrl[`BIT_CONVERTER_ON];
  assign RC_CLOCK_SEL_O = (s_r.timing_fmt[2:0] == `RC_CODE) ||
                          (s_r.timing_fmt[2:0] == `RC_DIV4_CODE); // [RL6] [RL21]
  assign DIGITAL_BUF_EN_O = ~{s_r.pin_hi, s_r.pin_lo}; // [RL9]
  assign CONV_IRQ_O = s_r.irq_flag;

endmodule

//--- inc/adc_seq_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 8-bit register port, 40 MHz system clock
// Notes: register offsets are indices on the plain register port
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

`define OFS_CONV_CTRL 4'h0
`define OFS_QUEUE_CTRL 4'h1
`define OFS_TIMING_FMT 4'h2
`define OFS_IRQ_TRIG 4'h3
`define OFS_GROUP_SEL 4'h4
`define OFS_PIN_SEL_LO 4'h5
`define OFS_PIN_SEL_HI 4'h6
`define OFS_RESULT_HI 4'h7
`define OFS_RESULT_LO 4'h8
`define OFS_IRQ_FLAG 4'h9

`define BIT_CONVERTER_ON 0
`define BIT_GO 1
`define BIT_MULTI_GROUP 4
`define BIT_LOOP_CONV 5
`define BIT_QUEUE_ENABLE 4
`define BIT_QUEUE_EMPTY 3
`define BIT_QUEUE_OVERRUN 2
`define BIT_JUSTIFY 7

`define RST_PIN_SEL_LO 8'hff
`define RST_PIN_SEL_HI 1'h1
`define RST_ZERO8 8'h00

`define CLK_PERIOD_NS 25
`define RC_PERIOD_NS 250
`define RC_DIV_CYCLES (`RC_PERIOD_NS / `CLK_PERIOD_NS)
`define RC_DIV4_CODE 3'h3
`define RC_CODE 3'h7

`endif

//--- inc/adc_seq_pkg.sv
// Purpose: types shared by the converter sequencer
// Assumes: constants live in adc_seq_cfg.svh
// Notes: none
package adc_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACQ = 3'b001,
    ST_CONV = 3'b010,
    ST_NEXT = 3'b011
  } seq_state_e;

  typedef struct packed {
    logic [9:0] data;
    logic done;
  } conv_result_s;

  typedef struct packed {
    logic [1:0] group;
    logic [3:0] channel;
    logic start;
  } conv_request_s;

endpackage

//--- test/conv_core_model.sv
// Purpose: behavioural converter core answering each start with one done pulse
// Assumes: result word is {channel, group, 4'h9} so the bench can predict it
// Notes: data toggles outside the done cycle so stale values never match
`timescale 1ns/100ps
module conv_core_model
  import adc_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [1:0] group_i,
  input wire logic [3:0] channel_i,
  input wire logic [7:0] delay_i,
  output conv_result_s result_o
);
  logic [7:0] cnt_r;
  logic [9:0] keep_r;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_r <= 8'h00;
      keep_r <= 10'h000;
      result_o <= '0;
    end
    else
    begin
      result_o.done <= 1'b0;
      result_o.data <= ~result_o.data;
      if (start_i)
      begin
        cnt_r <= delay_i;
        keep_r <= {channel_i, group_i, 4'h9};
      end
      else if (cnt_r != 8'h00)
      begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          result_o.done <= 1'b1;
          result_o.data <= keep_r;
        end
      end
    end
  end
endmodule

//--- test/adc_seq_ctrl_properties.sv
// Purpose: port timing relations of the sequencer
// Assumes: register indices and field positions of the design
// Notes: helper flops mirror a few written fields
`timescale 1ns/100ps
module adc_seq_ctrl_props
  import adc_seq_pkg::*;
#(
  parameter int PIN_COUNT = 9
)
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic [4:0] TRIG_I,
  input wire logic CONV_START_O,
  input wire logic PAIR_SAMPLE_O,
  input wire logic CONV_DONE_I,
  input wire logic CONVERTER_ON_O,
  input wire logic RC_CLOCK_SEL_O,
  input wire logic [8:0] DIGITAL_BUF_EN_O,
  input wire logic CONV_IRQ_O
);
  logic [4:0] mask_r;
  logic acq0_r;
  logic loop_r;
  logic multi_r;

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      mask_r <= 5'h00;
      acq0_r <= 1'b1;
      loop_r <= 1'b0;
      multi_r <= 1'b0;
    end
    else if (WR_I)
    begin
      if (ADDR_I == 4'h3)
        mask_r <= WDATA_I[4:0];
      if (ADDR_I == 4'h2)
        acq0_r <= (WDATA_I[6:3] == 4'h0);
      if (ADDR_I == 4'h0)
        loop_r <= WDATA_I[5];
      if (ADDR_I == 4'h0)
        multi_r <= WDATA_I[4];
    end
  end

  default clocking dc @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  AST_START_PULSE: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("start pulse too long");
  AST_RDATA_IDLE: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data outside answer cycle");
  AST_RESET_OFF: assert property ($rose(RESET_N_I) |-> !CONVERTER_ON_O && !CONV_IRQ_O)
    else $error("converter not off after reset");
  AST_GO_START: assert property (WR_I && ADDR_I == 4'h0 && WDATA_I[1:0] == 2'b11
    && !CONVERTER_ON_O && acq0_r |-> ##2 CONV_START_O)
    else $error("go did not start");
  AST_SINGLE_IRQ: assert property (CONV_DONE_I && CONVERTER_ON_O && !loop_r
    && !multi_r |-> ##[1:3] CONV_IRQ_O)
    else $error("no flag after single shot");
  AST_NO_TRIG: assert property (TRIG_I != $past(TRIG_I) && mask_r == 5'h00
    |-> !CONV_START_O [*8])
    else $error("masked trigger started");
  AST_TRIG_START: assert property ((TRIG_I & ~$past(TRIG_I) & mask_r) != 5'h00
    && CONVERTER_ON_O |-> ##[2:8] CONV_START_O)
    else $error("enabled trigger ignored");
  AST_PAIR: assert property (WR_I && ADDR_I == 4'h0 |=> ##1 PAIR_SAMPLE_O ==
    ($past(WDATA_I[4], 2) && $past(WDATA_I[3], 2)))
    else $error("paired level wrong");
  AST_RC_SEL: assert property (WR_I && ADDR_I == 4'h2 |=> ##1 RC_CLOCK_SEL_O ==
    ($past(WDATA_I[1:0], 2) == 2'b11))
    else $error("rc select wrong");
  AST_BUF_LO: assert property (WR_I && ADDR_I == 4'h5 |=> ##1
    DIGITAL_BUF_EN_O[7:0] == ~$past(WDATA_I, 2))
    else $error("digital buffer enable wrong");
  AST_BUF_HI: assert property (WR_I && ADDR_I == 4'h6 |=> ##1
    DIGITAL_BUF_EN_O[8] == !$past(WDATA_I[0], 2))
    else $error("pin eight buffer wrong");

  COV_TRIG: cover property ((TRIG_I & mask_r) != 5'h00 ##[1:8] CONV_START_O);
  COV_PAIR: cover property ($rose(PAIR_SAMPLE_O));
  COV_LOOP_IRQ: cover property (loop_r && $rose(CONV_IRQ_O));
endmodule

bind adc_seq_ctrl adc_seq_ctrl_props #(.PIN_COUNT(PIN_COUNT)) chk_u (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TRIG_I(TRIG_I),
  .CONV_START_O(CONV_START_O), .PAIR_SAMPLE_O(PAIR_SAMPLE_O),
  .CONV_DONE_I(CONV_DONE_I), .CONVERTER_ON_O(CONVERTER_ON_O),
  .RC_CLOCK_SEL_O(RC_CLOCK_SEL_O), .DIGITAL_BUF_EN_O(DIGITAL_BUF_EN_O),
  .CONV_IRQ_O(CONV_IRQ_O)
);

//--- test/test_adc_seq_ctrl.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: core model answers after a programmable delay
// Notes: sleep input is raised only in the acquisition test
`timescale 1ns/100ps
module test_adc_seq_ctrl
  import adc_seq_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [4:0] trig = 5'h00;
  logic sleep = 1'b0;
  logic [7:0] delay = 8'h03;
  logic [7:0] rdata;
  logic [1:0] grp;
  logic [3:0] chan;
  logic start, pair, conv_on, rc_sel, irq;
  logic [8:0] buf_en;
  conv_result_s res;
  int fails = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  adc_seq_ctrl #(.PIN_COUNT(9)) dut_u (
    .CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(we),
    .RD_I(re), .RDATA_O(rdata), .TRIG_I(trig), .SLEEP_I(sleep), .CONV_GROUP_O(grp),
    .CONV_CHANNEL_O(chan), .CONV_START_O(start), .PAIR_SAMPLE_O(pair),
    .CONV_DATA_I(res.data), .CONV_DONE_I(res.done), .CONVERTER_ON_O(conv_on),
    .RC_CLOCK_SEL_O(rc_sel), .DIGITAL_BUF_EN_O(buf_en), .CONV_IRQ_O(irq)
  );
  conv_core_model core_u (
    .clk_i(clk), .reset_n_i(rst_n), .start_i(start), .group_i(grp),
    .channel_i(chan), .delay_i(delay), .result_o(res)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk8(rdata, exp, msg);
  endtask

  // which: 0 start, 1 interrupt, 2 core done; t is the cycle seen or -1
  task automatic wait_hi(input int which, input int n, output int t);
    t = -1;
    for (int i = 1; i <= n && t < 0; i++)
    begin
      @(posedge clk);
      #1;
      if ((which == 0 ? start : which == 1 ? irq : res.done) === 1'b1)
        t = i;
    end
  endtask

  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    trig <= v;
    @(posedge clk);
    trig <= 5'h00;
  endtask

  task automatic t_reset();
    logic [7:0] e [10] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++)
      rd_chk(4'(i), e[i], "reset value");
    rd_chk(4'hc, 8'h00, "unmapped");
    chk8({7'h0, buf_en == 9'h000}, 8'h01, "buffers off");
    reg_wr(4'h6, 8'hff);
    rd_chk(4'h6, 8'h01, "pin eight");
    reg_wr(4'h5, 8'h0f);
    tick(2);
    chk8(buf_en[7:0], 8'hf0, "digital buffers");
    rd_chk(4'h5, 8'h0f, "pin low");
  endtask

  task automatic t_groups();
    int g [9] = '{0, 0, 0, 1, 1, 2, 2, 3, 3};
    int c [9] = '{0, 1, 2, 0, 1, 0, 1, 0, 1};
    int sh [4] = '{0, 4, 2, 6};
    int t;
    logic [3:0] ch;
    logic [9:0] d;
    reg_wr(4'h3, 8'h80);
    for (int i = 0; i < 9; i++)
    begin
      ch = 4'(g[i] == 0 ? 4 * c[i] : g[i] + 4 * c[i]);
      d = {ch, 2'(g[i]), 4'h9};
      reg_wr(4'h4, 8'(c[i] << sh[g[i]]));
      reg_wr(4'h0, 8'(g[i] << 2) | 8'h03);
      wait_hi(0, 30, t);
      chk8({4'h0, chan}, {4'h0, ch}, "channel");
      chk8({6'h0, grp}, 8'(g[i]), "group");
      wait_hi(1, 60, t);
      chk8({7'h0, t > 0}, 8'h01, "single flag");
      rd_chk(4'h0, 8'(g[i] << 2) | 8'h01, "go cleared");
      rd_chk(4'h7, d[9:2], "left high");
      rd_chk(4'h8, {d[1:0], 6'h00}, "left low");
      reg_wr(4'h9, 8'h00);
    end
    reg_wr(4'h3, 8'h00);
  endtask

  task automatic t_modes();
    logic [7:0] seq;
    int n;
    logic [7:0] es [4] = '{8'h01, 8'h1b, 8'h01, 8'h1b};
    reg_wr(4'h4, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      seq = 8'h00;
      n = 0;
      reg_wr(4'h0, 8'(m << 2) | 8'h13);
      for (int i = 0; i < 120 && irq !== 1'b1; i++)
      begin
        @(posedge clk);
        #1;
        if (start === 1'b1)
        begin
          n++;
          seq = {seq[5:0], grp};
        end
      end
      chk8(8'(n), m[0] ? 8'h04 : 8'h02, "conversions");
      chk8(seq, es[m], "group order");
      chk8({7'h0, pair}, {7'h0, m[1]}, "paired");
      reg_wr(4'h9, 8'h00);
    end
  endtask

  task automatic t_queue();
    int t;
    logic [9:0] d;
    // fresh queue: earlier scenarios leave an unread entry and a sticky overrun
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(2);
    delay <= 8'h09;
    reg_wr(4'h1, 8'h10);
    reg_wr(4'h2, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      reg_wr(4'h0, 8'h17);
      wait_hi(1, 200, t);
      reg_wr(4'h9, 8'h00);
      rd_chk(4'h1, k ? 8'h14 : 8'h10, "queue status");
      if (k == 0)
        rd_chk(4'h8, 8'h09, "first low");
    end
    for (int i = 0; i < 4; i++)
    begin
      d = {4'(i), 2'(i), 4'h9};
      rd_chk(4'h7, {6'h00, d[9:8]}, "right high");
      rd_chk(4'h8, d[7:0], "right low");
      rd_chk(4'h1, 8'h14 | (i == 3 ? 8'h08 : 8'h00) | 8'((i + 1) % 4), "pointer");
    end
  endtask

  task automatic t_loop();
    int t;
    int first [3] = '{1, 2, 4};
    for (int dp = 0; dp < 3; dp++)
    begin
      reg_wr(4'h3, 8'(dp << 6));
      reg_wr(4'h9, 8'h00);
      reg_wr(4'h0, 8'h23);
      for (int k = 1; k <= 4; k++)
      begin
        wait_hi(2, 40, t);
        tick(4);
        chk8({7'h0, irq}, {7'h0, k >= first[dp]}, "depth flag");
      end
      reg_wr(4'h0, 8'h00);
      tick(12);
    end
    reg_wr(4'h9, 8'h00);
  endtask

  task automatic t_trig();
    int t;
    logic [4:0] m [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h05, 5'h05};
    logic [4:0] s [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h04, 5'h01};
    reg_wr(4'h0, 8'h01);
    reg_wr(4'h3, 8'h00);
    pulse(5'h1f);
    wait_hi(0, 12, t);
    chk8({7'h0, t < 0}, 8'h01, "masked triggers");
    for (int i = 0; i < 7; i++)
    begin
      reg_wr(4'h3, {3'h0, m[i]});
      pulse(s[i]);
      wait_hi(0, 12, t);
      chk8({7'h0, t > 0}, 8'h01, "trigger start");
      wait_hi(1, 40, t);
      reg_wr(4'h9, 8'h00);
    end
  endtask

  task automatic t_acq();
    int t;
    reg_wr(4'h2, 8'h0b);
    tick(1);
    chk8({7'h0, rc_sel}, 8'h01, "rc select");
    reg_wr(4'h0, 8'h03);
    wait_hi(0, 200, t);
    chk8({7'h0, t >= 80 && t <= 84}, 8'h01, "acquisition delay");
    wait_hi(1, 40, t);
    sleep <= 1'b1;
    reg_wr(4'h0, 8'h03);
    rd_chk(4'h0, 8'h01, "sleep abort");
    reg_wr(4'h2, 8'h0f);
    reg_wr(4'h0, 8'h03);
    rd_chk(4'h0, 8'h03, "sleep on rc clock");
    sleep <= 1'b0;
    tick(20);
    rst_n <= 1'b0;
    tick(2);
    chk8({6'h0, conv_on, irq}, 8'h00, "reset stops");
    rst_n <= 1'b1;
    tick(2);
    rd_chk(4'h0, 8'h00, "control cleared");
    rd_chk(4'h2, 8'h00, "timing cleared");
    wait_hi(0, 100, t);
    chk8({7'h0, t < 0}, 8'h01, "abandoned");
  endtask

  task automatic results();
    $display("checks %0d failures %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    $display("reset test done");
    t_groups();
    $display("group test done");
    t_modes();
    $display("mode test done");
    t_queue();
    $display("queue test done");
    t_loop();
    $display("loop test done");
    t_trig();
    $display("trigger test done");
    t_acq();
    $display("acquisition test done");
    results();
  end

  initial
  begin
    #(25 * 20000);
    fails++;
    $display("CHECK FAILED %0t: watchdog", $time);
    results();
  end
endmodule
